// *** lsl_pkg.sv ***
package lsl_pkg;
    // Operating modes of one look-up table
    typedef enum logic [1:0] {
        LSL_LUT_LOGIC,
        LSL_LUT_RAM,
        LSL_LUT_SHIFT
    } lsl_lut_mode_t;

    localparam int LSL_LUT_INPUTS = 4;
    localparam int LSL_LUT_DEPTH  = 16;
    localparam logic [LSL_LUT_DEPTH-1:0] LSL_LUT_RESET = 16'h0000;

    // Storage element values under rst_i
    localparam logic LSL_STORE_RESET = 1'b0;
    localparam logic LSL_PEND_RESET  = 1'b1;
    localparam logic LSL_RUN_RESET   = 1'b0;

    // Bit positions in the control polarity vector
    localparam int LSL_POL_CE   = 0;
    localparam int LSL_POL_SR   = 1;
    localparam int LSL_POL_GATE = 2;
    localparam int LSL_POL_BX   = 3;
    localparam int LSL_POL_BY   = 4;
    localparam int LSL_POL_W    = 5;
endpackage

// *** lsl_lut.sv ***
module lsl_lut
    import lsl_pkg::*;
#(
    parameter int AW     = LSL_LUT_INPUTS,
    parameter bit MEM_OK = 1'b1
) (
    input  wire logic            ref_clk_i,
    input  wire logic            rst_i,
    input  wire logic            cfg_load_i,
    input  wire logic [2**AW-1:0] cfg_init_i,
    input  wire lsl_lut_mode_t   mode_i,
    input  wire logic [AW-1:0]   addr_i,
    input  wire logic            wr_en_i,
    input  wire logic            wr_data_i,
    input  wire logic            shift_en_i,
    input  wire logic            shift_in_i,
    output logic                 d_o,
    output logic                 shift_out_o
);
    localparam int DEPTH = 2**AW;

    typedef struct packed {
        logic [DEPTH-1:0] mem;
    } lsl_lut_state_t;

    lsl_lut_state_t s_q;
    lsl_lut_state_t s_d;

    ////////////////////////////////////////////////////////////////////
    // Contents change only by loading or in memory modes
    always_comb begin
        s_d = s_q;
        if (cfg_load_i) begin
            s_d.mem = cfg_init_i; // RULE22
        end else if (MEM_OK) begin
            case (mode_i)
                LSL_LUT_RAM: begin
                    if (wr_en_i) begin
                        s_d.mem[addr_i] = wr_data_i; // RULE17
                    end
                end
                LSL_LUT_SHIFT: begin
                    if (shift_en_i) begin
                        s_d.mem = {s_q.mem[DEPTH-2:0], shift_in_i}; // RULE17
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.mem <= LSL_LUT_RESET[DEPTH-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    // Any function of the inputs is a table read
    assign d_o         = s_q.mem[addr_i]; // RULE1
    assign shift_out_o = s_q.mem[DEPTH-1];
endmodule

// *** lsl_store.sv ***
module lsl_store
    import lsl_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    input  wire logic ce_i,
    input  wire logic gate_i,
    input  wire logic sr_i,
    input  wire logic rev_i,
    input  wire logic latch_mode_i,
    input  wire logic sr_async_i,
    input  wire logic sr_high_i,
    input  wire logic init_high_i,
    input  wire logic gsr_i,
    output logic      q_o
);
    typedef struct packed {
        logic q;
        logic pend;
    } lsl_store_state_t;

    lsl_store_state_t s_q;
    lsl_store_state_t s_d;
    logic             force_lo;
    logic             force_hi;
    logic             transp;

    ////////////////////////////////////////////////////////////////////
    // Reset side of the pair dominates
    assign force_lo = (sr_i & ~sr_high_i) | (rev_i & sr_high_i); // RULE19
    assign force_hi = (sr_i & sr_high_i) | (rev_i & ~sr_high_i); // RULE14
    assign transp   = gate_i & ce_i;

    always_comb begin
        s_d      = s_q;
        s_d.pend = 1'b0;
        if (s_q.pend | gsr_i) begin
            s_d.q = init_high_i; // RULE21
        end else if (force_lo) begin
            s_d.q = 1'b0; // RULE10 RULE20
        end else if (force_hi) begin
            s_d.q = 1'b1; // RULE9
        end else if (latch_mode_i) begin
            s_d.q = transp ? d_i : s_q.q; // RULE8
        end else if (ce_i) begin
            s_d.q = d_i; // RULE7
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.q    <= LSL_STORE_RESET;
            s_q.pend <= LSL_PEND_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Latch and asynchronous forcing act without waiting for an edge
    always_comb begin
        if (s_q.pend) begin
            q_o = init_high_i;
        end else if (latch_mode_i) begin
            if (force_lo) begin
                q_o = 1'b0; // RULE12
            end else if (force_hi) begin
                q_o = 1'b1; // RULE11
            end else begin
                q_o = transp ? d_i : s_q.q; // RULE5
            end
        end else if (sr_async_i & force_lo) begin
            q_o = 1'b0; // RULE12
        end else if (sr_async_i & force_hi) begin
            q_o = 1'b1; // RULE11
        end else begin
            q_o = s_q.q;
        end
    end
endmodule

// *** lsl_slice.sv ***
// How it works
// RULE1: two four-input tables, each any Boolean function of its inputs
// RULE2: table output feeds wide mux, carry, slice output or storage
// RULE3: lower wide mux picks between the two tables of this slice
// RULE4: upper wide mux picks between two wide results fed from outside
// RULE5: each storage element is a flip-flop or a transparent latch
// RULE6: storage data is the combinational output or the bypass input
// RULE7: flip-flop loads on edge with enable high, set and reset low
// RULE8: latch follows while gate and enable high, holds otherwise
// RULE9: synchronous set lifts a flip-flop at the edge, a latch at once
// RULE10: synchronous reset beats synchronous set, output goes low
// RULE11: asynchronous preset forces high immediately, in flip-flop and latch mode
// RULE12: asynchronous clear beats preset, output forced low
// RULE13: one shared set/reset acts as reset, set, clear or preset
// RULE14: opposite-state input forces the other state, same sync mode
// RULE15: clock, enable, set and reset are common to both elements
// RULE16: every storage control has selectable polarity, active high default; the clock has no polarity setting here
// RULE17: memory-capable tables also work as memory or 16-bit shifter
// RULE18: carry gates and muxes also serve as general wide logic
// RULE19: shared set/reset forces the per-element high or low target
// RULE20: with set/reset and opposite-state both active, reset wins
// RULE21: after global set/reset each element takes its initial value
// RULE22: table contents load by configuration, constant in logic mode
module lsl_slice
    import lsl_pkg::*;
#(
    parameter bit MEMORY_CAPABLE_SLICE = 1'b1
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      cfg_load_i,
    input  wire logic [LSL_LUT_DEPTH-1:0]  cfg_init_lower_i,
    input  wire logic [LSL_LUT_DEPTH-1:0]  cfg_init_upper_i,
    input  wire lsl_lut_mode_t             cfg_lut_mode_i,
    input  wire logic [LSL_POL_W-1:0]      cfg_pol_inv_i,
    input  wire logic                      cfg_latch_mode_i,
    input  wire logic                      cfg_sr_async_i,
    input  wire logic                      cfg_rev_en_i,
    input  wire logic                      cfg_d_bypass_lower_i,
    input  wire logic                      cfg_d_bypass_upper_i,
    input  wire logic                      cfg_arith_lower_i,
    input  wire logic                      cfg_arith_upper_i,
    input  wire logic                      cfg_and_di_lower_i,
    input  wire logic                      cfg_and_di_upper_i,
    input  wire logic                      set_reset_high_lower_i,
    input  wire logic                      set_reset_high_upper_i,
    input  wire logic                      initial_high_lower_i,
    input  wire logic                      initial_high_upper_i,
    input  wire logic [LSL_LUT_INPUTS-1:0] lut_logic_inputs_lower_i,
    input  wire logic [LSL_LUT_INPUTS-1:0] lut_logic_inputs_upper_i,
    input  wire logic                      bypass_lower_in_i,
    input  wire logic                      bypass_upper_in_i,
    input  wire logic                      wide_in_a_i,
    input  wire logic                      wide_in_b_i,
    input  wire logic                      carry_in_i,
    input  wire logic                      clk_en_i,
    input  wire logic                      latch_gate_i,
    input  wire logic                      shared_set_reset_in_i,
    input  wire logic                      shift_in_i,
    input  wire logic                      global_set_reset_i,
    output logic                           comb_lower_o,
    output logic                           comb_upper_o,
    output logic                           wide_mux_lower_o,
    output logic                           wide_mux_upper_o,
    output logic                           carry_out_o,
    output logic                           storage_lower_o,
    output logic                           storage_upper_o,
    output logic                           shift_out_o
);
    typedef struct packed {
        logic run;
    } lsl_slice_state_t;

    lsl_slice_state_t s_q;
    lsl_slice_state_t s_d;

    logic          ce;
    logic          sr;
    logic          gate;
    logic          bx;
    logic          by;
    logic          opposite_state_in;
    logic          lut_lower;
    logic          lut_upper;
    logic          srl_lower;
    logic          srl_upper;
    logic          carry_mid;
    logic          sum_lower;
    logic          sum_upper;
    logic          di_lower;
    logic          di_upper;
    logic          d_lower;
    logic          d_upper;
    lsl_lut_mode_t mode;

    ////////////////////////////////////////////////////////////////////
    // Control polarity, one setting per shared control
    assign ce   = clk_en_i ^ cfg_pol_inv_i[LSL_POL_CE]; // RULE16
    assign sr   = shared_set_reset_in_i ^ cfg_pol_inv_i[LSL_POL_SR]; // RULE16
    assign gate = latch_gate_i ^ cfg_pol_inv_i[LSL_POL_GATE]; // RULE16
    assign bx   = bypass_lower_in_i ^ cfg_pol_inv_i[LSL_POL_BX]; // RULE16
    assign by   = bypass_upper_in_i ^ cfg_pol_inv_i[LSL_POL_BY]; // RULE16
    // Upper bypass doubles as the opposite-state control
    assign opposite_state_in  = cfg_rev_en_i & by; // RULE14

    // A slice without memory keeps its tables in logic mode
    assign mode = MEMORY_CAPABLE_SLICE ? cfg_lut_mode_i : LSL_LUT_LOGIC;

    ////////////////////////////////////////////////////////////////////
    // Look-up tables; memory writes share the set/reset line
    lsl_lut #(
        .AW     (LSL_LUT_INPUTS),
        .MEM_OK (MEMORY_CAPABLE_SLICE)
    ) u_lut_lower (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .cfg_load_i  (cfg_load_i),
        .cfg_init_i  (cfg_init_lower_i),
        .mode_i      (mode),
        .addr_i      (lut_logic_inputs_lower_i),
        .wr_en_i     (sr),
        .wr_data_i   (bx),
        .shift_en_i  (ce),
        .shift_in_i  (srl_upper),
        .d_o         (lut_lower),
        .shift_out_o (srl_lower)
    );

    lsl_lut #(
        .AW     (LSL_LUT_INPUTS),
        .MEM_OK (MEMORY_CAPABLE_SLICE)
    ) u_lut_upper (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .cfg_load_i  (cfg_load_i),
        .cfg_init_i  (cfg_init_upper_i),
        .mode_i      (mode),
        .addr_i      (lut_logic_inputs_upper_i),
        .wr_en_i     (sr),
        .wr_data_i   (by),
        .shift_en_i  (ce),
        .shift_in_i  (shift_in_i),
        .d_o         (lut_upper),
        .shift_out_o (srl_upper)
    );

    assign shift_out_o = srl_lower;

    ////////////////////////////////////////////////////////////////////
    // Wide multiplexers
    assign wide_mux_lower_o = bx ? lut_upper : lut_lower; // RULE3
    assign wide_mux_upper_o = by ? wide_in_b_i : wide_in_a_i; // RULE4

    ////////////////////////////////////////////////////////////////////
    // Carry and arithmetic; the AND gate gives a spare wide function
    assign di_lower  = cfg_and_di_lower_i ?
                       (lut_logic_inputs_lower_i[0] &
                        lut_logic_inputs_lower_i[1]) : bx; // RULE18
    assign di_upper  = cfg_and_di_upper_i ?
                       (lut_logic_inputs_upper_i[0] &
                        lut_logic_inputs_upper_i[1]) : by; // RULE18
    assign carry_mid   = lut_lower ? carry_in_i : di_lower; // RULE2
    assign carry_out_o = lut_upper ? carry_mid : di_upper; // RULE2
    assign sum_lower   = lut_lower ^ carry_in_i; // RULE2
    assign sum_upper   = lut_upper ^ carry_mid; // RULE2

    assign comb_lower_o = cfg_arith_lower_i ? sum_lower : lut_lower; // RULE2
    assign comb_upper_o = cfg_arith_upper_i ? sum_upper : lut_upper; // RULE2

    ////////////////////////////////////////////////////////////////////
    // Storage elements on common controls
    assign d_lower = cfg_d_bypass_lower_i ? bx : comb_lower_o; // RULE6
    assign d_upper = cfg_d_bypass_upper_i ? by : comb_upper_o; // RULE6

    // Shared set/reset role follows the target and the sync setting
    lsl_store u_storage_lower (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .d_i          (d_lower),
        .ce_i         (ce), // RULE15
        .gate_i       (gate),
        .sr_i         (sr), // RULE13
        .rev_i        (opposite_state_in),
        .latch_mode_i (cfg_latch_mode_i),
        .sr_async_i   (cfg_sr_async_i),
        .sr_high_i    (set_reset_high_lower_i),
        .init_high_i  (initial_high_lower_i),
        .gsr_i        (global_set_reset_i),
        .q_o          (storage_lower_o)
    );

    lsl_store u_storage_upper (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .d_i          (d_upper),
        .ce_i         (ce), // RULE15
        .gate_i       (gate),
        .sr_i         (sr), // RULE13
        .rev_i        (opposite_state_in),
        .latch_mode_i (cfg_latch_mode_i),
        .sr_async_i   (cfg_sr_async_i),
        .sr_high_i    (set_reset_high_upper_i),
        .init_high_i  (initial_high_upper_i),
        .gsr_i        (global_set_reset_i),
        .q_o          (storage_upper_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Marks the end of the initial-value cycle after reset
    always_comb begin
        s_d     = s_q;
        s_d.run = 1'b1;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.run <= LSL_RUN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_ff_capture: // RULE7
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && !cfg_latch_mode_i
        && !cfg_sr_async_i
        && ce
        && !sr
        && !opposite_state_in
        && !global_set_reset_i
        |=> storage_lower_o == $past(d_lower))
    else $error("lower flip-flop missed its data");

    a_ff_hold: // RULE7
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && !cfg_latch_mode_i
        && !cfg_sr_async_i
        && !ce
        && !sr
        && !opposite_state_in
        && !global_set_reset_i
        |=> $stable(storage_upper_o))
    else $error("upper flip-flop changed without enable");

    a_sync_set: // RULE9
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && !cfg_latch_mode_i
        && !cfg_sr_async_i
        && sr
        && !opposite_state_in
        && set_reset_high_lower_i
        && !global_set_reset_i
        |-> ##1 storage_lower_o)
    else $error("synchronous set did not raise output");

    a_reset_wins: // RULE10
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && !cfg_latch_mode_i
        && !cfg_sr_async_i
        && sr
        && opposite_state_in
        && !global_set_reset_i
        |=> !storage_lower_o && !storage_upper_o)
    else $error("reset did not dominate set");

    a_async_preset: // RULE11
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && cfg_sr_async_i
        && sr
        && !opposite_state_in
        && set_reset_high_lower_i
        |-> storage_lower_o)
    else $error("preset did not force output high");

    a_async_clear: // RULE12
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && cfg_sr_async_i
        && sr
        && opposite_state_in
        |-> !storage_lower_o && !storage_upper_o)
    else $error("clear did not beat preset");

    a_latch_follow: // RULE8
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && cfg_latch_mode_i
        && gate
        && ce
        && !sr
        && !opposite_state_in
        |-> storage_lower_o == d_lower)
    else $error("open latch did not follow data");

    a_latch_hold: // RULE8
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_q.run
        && cfg_latch_mode_i
        && !global_set_reset_i
        ##1 cfg_latch_mode_i
        && !(gate && ce)
        && !sr
        && !opposite_state_in
        |-> storage_upper_o == $past(storage_upper_o))
    else $error("closed latch did not hold");

    a_gsr_init: // RULE21
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        global_set_reset_i
        && !cfg_latch_mode_i
        && !cfg_sr_async_i
        |=> storage_lower_o == $past(initial_high_lower_i))
    else $error("global set/reset missed initial value");

    a_wide_lower: // RULE3
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wide_mux_lower_o
        == (bx ? lut_upper : lut_lower))
    else $error("lower wide mux picked wrong table");

    a_carry_prop: // RULE2
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        lut_lower
        && lut_upper
        |-> carry_out_o == carry_in_i)
    else $error("carry did not propagate");

    a_lut_const: // RULE22
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mode == LSL_LUT_LOGIC
        && !cfg_load_i
        ##1 $stable(lut_logic_inputs_lower_i)
        |-> $stable(lut_lower))
    else $error("table changed in logic mode");

    a_srl_shift: // RULE17
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        MEMORY_CAPABLE_SLICE
        && cfg_lut_mode_i == LSL_LUT_SHIFT
        && ce
        && !cfg_load_i
        |=> srl_upper == $past(u_lut_upper.s_q.mem[LSL_LUT_DEPTH-2]))
    else $error("shift register did not advance");
endmodule

// *** lsl_slice_tb.sv ***
module lsl_slice_tb
    import lsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [LSL_LUT_DEPTH-1:0] LO = 16'hA5C3;
    localparam logic [LSL_LUT_DEPTH-1:0] UP = 16'h3C96;

    logic                      ref_clk_i, rst_i, cfg_load_i;
    logic [LSL_LUT_DEPTH-1:0]  cfg_init_lower_i, cfg_init_upper_i;
    lsl_lut_mode_t             cfg_lut_mode_i;
    logic [LSL_POL_W-1:0]      cfg_pol_inv_i;
    logic                      cfg_latch_mode_i, cfg_sr_async_i, cfg_rev_en_i;
    logic                      cfg_d_bypass_lower_i, cfg_d_bypass_upper_i;
    logic                      cfg_arith_lower_i, cfg_arith_upper_i;
    logic                      cfg_and_di_lower_i, cfg_and_di_upper_i;
    logic                      set_reset_high_lower_i, set_reset_high_upper_i;
    logic                      initial_high_lower_i, initial_high_upper_i;
    logic [LSL_LUT_INPUTS-1:0] lut_logic_inputs_lower_i;
    logic [LSL_LUT_INPUTS-1:0] lut_logic_inputs_upper_i;
    logic                      bypass_lower_in_i, bypass_upper_in_i;
    logic                      wide_in_a_i, wide_in_b_i, carry_in_i, clk_en_i;
    logic                      latch_gate_i, shared_set_reset_in_i, shift_in_i;
    logic                      global_set_reset_i;
    logic                      comb_lower_o, comb_upper_o, wide_mux_lower_o;
    logic                      wide_mux_upper_o, carry_out_o, storage_lower_o;
    logic                      storage_upper_o, shift_out_o;
    logic                      w0, w1;
    int                        n_mismatch, checked, n;

    lsl_slice #(.MEMORY_CAPABLE_SLICE(1'h1)) lsl_slice_i (.*);

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'h0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask

    task automatic smp;
        @(negedge ref_clk_i);
    endtask

    task automatic chk(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic qchk(input logic el, input logic eu, input string m);
        chk(storage_lower_o, el, m);
        chk(storage_upper_o, eu, m);
    endtask

    task automatic summarize;
        $display("Checks: %0d, mismatches: %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_i = 1'h1;
        {cfg_load_i, cfg_init_lower_i, cfg_init_upper_i, cfg_pol_inv_i,
         cfg_latch_mode_i, cfg_sr_async_i, cfg_rev_en_i, cfg_arith_lower_i,
         cfg_arith_upper_i, cfg_and_di_lower_i, cfg_and_di_upper_i,
         set_reset_high_upper_i, initial_high_upper_i, carry_in_i,
         lut_logic_inputs_lower_i, lut_logic_inputs_upper_i, shift_in_i,
         bypass_lower_in_i, bypass_upper_in_i, wide_in_a_i, wide_in_b_i,
         clk_en_i, latch_gate_i, shared_set_reset_in_i,
         global_set_reset_i} = '0;
        {cfg_d_bypass_lower_i, cfg_d_bypass_upper_i, set_reset_high_lower_i,
         initial_high_lower_i} = 4'hF;
        cfg_lut_mode_i = LSL_LUT_LOGIC;
        cyc(20);
        smp;
        qchk(1'h1, 1'h0, "value under reset");
        cyc(1);
        rst_i <= 1'h0;
        cyc(2);
        smp;
        qchk(1'h1, 1'h0, "initial value");
        // Tables load once; later init inputs are ignored
        cyc(1);
        cfg_init_lower_i <= LO;
        cfg_init_upper_i <= UP;
        cfg_load_i <= 1'h1;
        cyc(1);
        cfg_load_i <= 1'h0;
        cfg_init_upper_i <= 16'hFFFF;
        for (int a = 0; a < 16; a++) begin
            cyc(1);
            lut_logic_inputs_lower_i <= 4'(a);
            lut_logic_inputs_upper_i <= 4'(15 - a);
            smp;
            chk(comb_lower_o, LO[a], "lower table");
            chk(comb_upper_o, UP[15 - a], "upper table");
        end
        // Wide multiplexers with address 0: lower table 1, upper table 0
        cyc(1);
        lut_logic_inputs_lower_i <= 4'h0;
        lut_logic_inputs_upper_i <= 4'h0;
        wide_in_a_i <= 1'h1;
        smp;
        w0 = wide_mux_lower_o;
        chk(wide_mux_upper_o, 1'h1, "upper wide mux a");
        cyc(1);
        bypass_lower_in_i <= 1'h1;
        bypass_upper_in_i <= 1'h1;
        smp;
        w1 = wide_mux_lower_o;
        chk(wide_mux_upper_o, 1'h0, "upper wide mux b");
        chk(w0 ^ w1, 1'h1, "lower wide mux select");
        cyc(1);
        cfg_pol_inv_i <= 5'h18;
        smp;
        chk(wide_mux_lower_o, w0, "lower select polarity");
        chk(wide_mux_upper_o, 1'h1, "upper select polarity");
        // Flip-flops from the bypass inputs, then from the tables
        cyc(1);
        cfg_pol_inv_i <= 5'h00;
        bypass_lower_in_i <= 1'h0;
        bypass_upper_in_i <= 1'h1;
        cyc(1);
        smp;
        qchk(1'h1, 1'h0, "enable low holds");
        cyc(1);
        clk_en_i <= 1'h1;
        smp;
        qchk(1'h1, 1'h0, "no change before edge");
        cyc(1);
        smp;
        qchk(1'h0, 1'h1, "both load at edge");
        cyc(1);
        cfg_pol_inv_i <= 5'h01;
        bypass_lower_in_i <= 1'h1;
        bypass_upper_in_i <= 1'h0;
        cyc(1);
        smp;
        qchk(1'h0, 1'h1, "inverted enable holds");
        cyc(1);
        cfg_pol_inv_i <= 5'h00;
        cyc(1);
        smp;
        qchk(1'h1, 1'h0, "enable restored");
        cyc(1);
        cfg_d_bypass_lower_i <= 1'h0;
        cfg_d_bypass_upper_i <= 1'h0;
        lut_logic_inputs_lower_i <= 4'h5;
        lut_logic_inputs_upper_i <= 4'hA;
        cyc(1);
        smp;
        qchk(1'h0, 1'h1, "data from tables");
        chk(carry_out_o, 1'h1, "carry from bypass");
        // Synchronous set/reset and opposite state
        cyc(1);
        clk_en_i <= 1'h0;
        cfg_d_bypass_lower_i <= 1'h1;
        cfg_d_bypass_upper_i <= 1'h1;
        shared_set_reset_in_i <= 1'h1;
        smp;
        qchk(1'h0, 1'h1, "sync set waits for edge");
        cyc(1);
        smp;
        qchk(1'h1, 1'h0, "sync set and reset");
        cyc(1);
        cfg_rev_en_i <= 1'h1;
        bypass_upper_in_i <= 1'h1;
        cyc(1);
        smp;
        qchk(1'h0, 1'h0, "reset dominates");
        cyc(1);
        shared_set_reset_in_i <= 1'h0;
        cyc(1);
        smp;
        qchk(1'h0, 1'h1, "opposite state");
        // Asynchronous preset and clear
        cyc(1);
        cfg_rev_en_i <= 1'h0;
        bypass_upper_in_i <= 1'h0;
        cfg_sr_async_i <= 1'h1;
        cyc(1);
        shared_set_reset_in_i <= 1'h1;
        smp;
        qchk(1'h1, 1'h0, "async forces at once");
        cyc(1);
        cfg_rev_en_i <= 1'h1;
        bypass_upper_in_i <= 1'h1;
        smp;
        qchk(1'h0, 1'h0, "clear beats preset");
        cyc(1);
        shared_set_reset_in_i <= 1'h0;
        cfg_rev_en_i <= 1'h0;
        bypass_upper_in_i <= 1'h0;
        cfg_sr_async_i <= 1'h0;
        // Global set/reset
        cyc(1);
        initial_high_upper_i <= 1'h1;
        global_set_reset_i <= 1'h1;
        smp;
        qchk(1'h0, 1'h0, "global reset waits for edge");
        cyc(1);
        global_set_reset_i <= 1'h0;
        smp;
        qchk(1'h1, 1'h1, "global reset initial");
        // Latch mode
        cyc(1);
        cfg_latch_mode_i <= 1'h1;
        latch_gate_i <= 1'h1;
        clk_en_i <= 1'h1;
        bypass_lower_in_i <= 1'h0;
        bypass_upper_in_i <= 1'h1;
        smp;
        qchk(1'h0, 1'h1, "latch transparent");
        cyc(1);
        bypass_lower_in_i <= 1'h1;
        bypass_upper_in_i <= 1'h0;
        smp;
        qchk(1'h1, 1'h0, "latch follows");
        cyc(1);
        latch_gate_i <= 1'h0;
        cyc(1);
        bypass_lower_in_i <= 1'h0;
        bypass_upper_in_i <= 1'h1;
        smp;
        qchk(1'h1, 1'h0, "latch holds, gate low");
        cyc(1);
        latch_gate_i <= 1'h1;
        clk_en_i <= 1'h0;
        smp;
        qchk(1'h1, 1'h0, "latch holds, enable low");
        cyc(1);
        set_reset_high_lower_i <= 1'h0;
        set_reset_high_upper_i <= 1'h1;
        shared_set_reset_in_i <= 1'h1;
        smp;
        qchk(1'h0, 1'h1, "latch set at once");
        // Memory mode writes
        cyc(1);
        shared_set_reset_in_i <= 1'h0;
        cfg_latch_mode_i <= 1'h0;
        latch_gate_i <= 1'h0;
        cfg_lut_mode_i <= LSL_LUT_RAM;
        bypass_lower_in_i <= 1'h1;
        bypass_upper_in_i <= 1'h0;
        smp;
        chk(comb_lower_o, 1'h0, "logic mode ignores write");
        chk(comb_upper_o, 1'h1, "logic mode ignores write");
        cyc(1);
        shared_set_reset_in_i <= 1'h1;
        cyc(1);
        shared_set_reset_in_i <= 1'h0;
        smp;
        chk(comb_lower_o, 1'h1, "memory write lower");
        chk(comb_upper_o, 1'h0, "memory write upper");
        // Shift through both tables
        cyc(1);
        cfg_init_lower_i <= 16'h0000;
        cfg_init_upper_i <= 16'h0000;
        cfg_load_i <= 1'h1;
        cfg_lut_mode_i <= LSL_LUT_SHIFT;
        clk_en_i <= 1'h0;
        cyc(1);
        cfg_load_i <= 1'h0;
        shift_in_i <= 1'h1;
        clk_en_i <= 1'h1;
        cyc(1);
        shift_in_i <= 1'h0;
        n = 1;
        smp;
        while (shift_out_o !== 1'h1 && n < 40) begin
            cyc(1);
            n++;
            smp;
        end
        chk(shift_out_o, 1'h1, "shift output never rose");
        chk(n == 32, 1'h1, "two tables shift 32 bits");
        summarize();
    end
endmodule
